// [rtl/fpec_pkg.sv]
package fpec_pkg;
	localparam logic [7:0] OFS_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_ADDR_HI  = 8'h04;
	localparam logic [7:0] OFS_ADDR_LO  = 8'h08;
	localparam logic [7:0] OFS_KEY      = 8'h0c;
	localparam logic [7:0] OFS_SRC_HI   = 8'h10;
	localparam logic [7:0] OFS_SRC_LO   = 8'h14;
	localparam logic [7:0] OFS_ECC      = 8'h18;

	localparam int CTL_START     = 15;
	localparam int CTL_WR_ENABLE = 14;
	localparam int CTL_SEQ_ERROR = 13;
	localparam int CTL_STOP_IDLE = 12;
	localparam int CTL_ROW_COMP  = 9;
	localparam int CTL_UNDERRUN  = 8;
	localparam int ECC_FLAG      = 0;
	localparam int ECC_IRQ_EN    = 1;
	localparam int ECC_PRIO_LSB  = 4;

	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [2:0]  PRIO_RESET    = 3'h0;

	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [1:0] KEY_NONE   = 2'h0;
	localparam logic [1:0] KEY_HALF   = 2'h1;
	localparam logic [1:0] KEY_ARMED  = 2'h2;

	localparam logic [3:0] OP_DOUBLE_WORD = 4'h1;
	localparam logic [3:0] OP_ROW         = 4'h2;
	localparam logic [3:0] OP_PAGE_ERASE  = 4'h3;
	localparam logic [3:0] OP_BULK_ERASE  = 4'he;

	localparam logic [4:0]  ROW_LAST_PAIR = 5'h1f;
	localparam logic [1:0]  LAST_WORD_RAW = 2'h3;
	localparam logic [1:0]  LAST_WORD_CMP = 2'h2;
	localparam logic [23:0] PAIR_MASK     = 24'hfffffc;
	localparam logic [23:0] PAGE_MASK     = 24'hfffc00;
	localparam logic [23:0] PAIR_STEP     = 24'h000004;
	localparam logic [23:0] SRC_STEP      = 24'h000002;

	localparam int CLK_PERIOD_NS   = 20;
	localparam int VREG_DELAY_NS   = 10000;
	localparam int VREG_CYCLES     =
		(VREG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UNDERRUN_CYCLES = 64;

	typedef enum logic [2:0] {
		FPEC_IDLE,
		FPEC_WAITREG,
		FPEC_FETCH,
		FPEC_LOAD,
		FPEC_PROG
	} fpec_fsm_t;
endpackage : fpec_pkg

// [rtl/fpec_ecc.sv]
`timescale 1ns/1ps
// Hamming code with an overall parity bit over one 48-bit word pair.
module fpec_ecc #(
	parameter int DATA_W  = 48,
	parameter int CHECK_W = 6
) (
	input  wire logic [DATA_W-1:0]  encData,
	output logic      [CHECK_W:0]   encParity,
	input  wire logic [DATA_W-1:0]  decData,
	input  wire logic [CHECK_W:0]   decParity,
	output logic      [DATA_W-1:0]  decFixed,
	output logic                    decSingle,
	output logic                    decDouble
);
	logic [CHECK_W-1:0] encSyn;
	logic [CHECK_W-1:0] decSyn;
	logic [CHECK_W-1:0] syndrome;

	// Codeword position of a data bit: the n-th position that is not a
	// power of two, so every data bit owns a unique nonzero syndrome.
	function automatic logic [CHECK_W-1:0] codePos(input int idx);
		int n;
		logic [CHECK_W-1:0] r;
		n = 0;
		r = '0;
		for (int p = 3; p < (1 << CHECK_W); p++) begin
			if ((p & (p - 1)) != 0) begin
				if (n == idx) begin
					r = p[CHECK_W-1:0];
				end
				n++;
			end
		end
		return r;
	endfunction : codePos

	always_comb begin
		encSyn = '0;
		decSyn = '0;
		for (int i = 0; i < DATA_W; i++) begin
			if (encData[i]) begin
				encSyn = encSyn ^ codePos(i);
			end
			if (decData[i]) begin
				decSyn = decSyn ^ codePos(i);
			end
		end
		encParity = {(^encData) ^ (^encSyn), encSyn};
		syndrome  = decSyn ^ decParity[CHECK_W-1:0];
		decSingle = (^decData) ^ (^decParity);
		decDouble = !decSingle && (syndrome != '0);
	end

	// A double error leaves the data untouched because decSingle is low.
	genvar g;
	generate
		for (g = 0; g < DATA_W; g++) begin : g_fix
			assign decFixed[g] = decData[g] ^
				(decSingle && (syndrome == codePos(g)));
		end
	endgenerate
endmodule : fpec_ecc

// [rtl/fpec_ctrl.sv]
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module fpec_ctrl
	import fpec_pkg::*;
#(
	parameter int VREG_WAIT = VREG_CYCLES,
	parameter int UNDERRUN  = UNDERRUN_CYCLES
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 sysRst,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic [31:0]               hrdata,
	output logic                      hresp,
	output logic                      cpuStall,
	input  wire logic                 powerSaveReq,
	output logic                      powerSaveGrant,
	input  wire logic                 cpuIdle,
	output logic                      flashPowerDown,
	input  wire logic [47:0]          latchData,
	output logic                      flashReq,
	output logic [3:0]                flashOp,
	output logic [23:0]               flashAddr,
	output logic [54:0]               flashWrWord,
	input  wire logic                 flashDone,
	output logic                      ramReq,
	output logic [23:0]               ramAddr,
	input  wire logic                 ramAck,
	input  wire logic [15:0]          ramData,
	input  wire logic                 arrRdValid,
	input  wire logic [47:0]          arrRdData,
	input  wire logic [6:0]           arrRdParity,
	output logic                      rdValid,
	output logic [47:0]               rdData,
	output logic                      eccIrq,
	output logic [2:0]                eccPriority,
	output logic                      eccTrap,
	input  wire logic                 trapHandlerPresent,
	output logic                      resetReq
);
	import fpec_pkg::*;

	typedef struct packed {
		logic            startBit;
		logic            opWriteEnable;
		logic            sequenceErrorFlag;
		logic            stopInIdle;
		logic            rowDataCompressed;
		logic            rowUnderrunFlag;
		logic [3:0]      operationSelect;
		logic [7:0]      targetAddressHigh;
		logic [15:0]     targetAddressLow;
		logic [7:0]      srcHigh;
		logic [14:0]     srcLow;
		logic [1:0]      keyStage;
		logic            eccSingleErrorFlag;
		logic            eccSingleErrorIrqEnable;
		logic [2:0]      eccSingleErrorPriority;
		fpec_fsm_t       fsm;
		logic [1:0]      wordIdx;
		logic [4:0]      pairIdx;
		logic [47:0]     pairData;
		logic [15:0]     timer;
		logic            flashAsleep;
		logic [15:0]     vregTimer;
		logic            dataWrite;
		logic            readPending;
		logic [7:0]      dataAddr;
		logic            hreadyout;
		logic [31:0]     hrdata;
		logic            hresp;
		logic            cpuStall;
		logic            powerSaveGrant;
		logic            flashPowerDown;
		logic            flashReq;
		logic [3:0]      flashOp;
		logic [23:0]     flashAddr;
		logic [54:0]     flashWrWord;
		logic            ramReq;
		logic [23:0]     ramAddr;
		logic            rdValid;
		logic [47:0]     rdData;
		logic            eccIrq;
		logic            eccTrap;
		logic            resetReq;
	} fpec_regs_t;

	fpec_regs_t s;
	fpec_regs_t next_s;
	logic [6:0]  encParity;
	logic [47:0] decFixed;
	logic        decSingle;
	logic        decDouble;

	// Always in circuit: nothing can bypass the decoder on the read path.
	fpec_ecc #(
		.DATA_W  (48),
		.CHECK_W (6)
	) u_ecc (
		.encData   (s.pairData),
		.encParity (encParity),
		.decData   (arrRdData),
		.decParity (arrRdParity),
		.decFixed  (decFixed),
		.decSingle (decSingle),
		.decDouble (decDouble)
	);

	function automatic logic opValid(input logic [3:0] op);
		return (op == OP_DOUBLE_WORD) || (op == OP_ROW) ||
			(op == OP_PAGE_ERASE) || (op == OP_BULK_ERASE);
	endfunction : opValid

	logic [23:0] target;
	logic [23:0] source;
	logic        accept;
	logic        flashUsable;
	logic [1:0]  lastWord;

	always_comb begin
		target = {s.targetAddressHigh, s.targetAddressLow};
		source = {s.srcHigh, s.srcLow, 1'b0};
		accept = hsel && htrans[1] && hready;
		flashUsable = !s.flashAsleep && (s.vregTimer == 16'h0000);
		lastWord = s.rowDataCompressed ? LAST_WORD_CMP : LAST_WORD_RAW;
		next_s = s;

		// Write data phase: reads take one wait state so that a read right
		// after a write always sees the written value.
		if (s.dataWrite) begin
			next_s.dataWrite = 1'b0;
			next_s.keyStage = KEY_NONE;
			unique case (s.dataAddr)
			OFS_CONTROL: begin
				// The processor is stalled while busy, so writes are ignored.
				if (!s.startBit) begin
					next_s.opWriteEnable     = hwdata[CTL_WR_ENABLE];
					next_s.sequenceErrorFlag = hwdata[CTL_SEQ_ERROR];
					next_s.stopInIdle        = hwdata[CTL_STOP_IDLE];
					next_s.rowDataCompressed = hwdata[CTL_ROW_COMP];
					next_s.rowUnderrunFlag   = hwdata[CTL_UNDERRUN];
					next_s.operationSelect   = hwdata[3:0];
					if (hwdata[CTL_START]) begin
						if (s.keyStage == KEY_ARMED && hwdata[CTL_WR_ENABLE]
							&& opValid(hwdata[3:0])) begin
							next_s.startBit = 1'b1;
							next_s.fsm = FPEC_WAITREG;
						end else begin
							next_s.sequenceErrorFlag = 1'b1;
						end
					end
				end
			end
			OFS_ADDR_HI: next_s.targetAddressHigh = hwdata[7:0];
			OFS_ADDR_LO: next_s.targetAddressLow = hwdata[15:0];
			OFS_KEY: begin
				if (hwdata[7:0] == KEY_FIRST) begin
					next_s.keyStage = KEY_HALF;
				end else if (hwdata[7:0] == KEY_SECOND &&
					s.keyStage == KEY_HALF) begin
					next_s.keyStage = KEY_ARMED;
				end
			end
			OFS_SRC_HI: next_s.srcHigh = hwdata[7:0];
			OFS_SRC_LO: next_s.srcLow = hwdata[15:1];
			OFS_ECC: begin
				next_s.eccSingleErrorIrqEnable = hwdata[ECC_IRQ_EN];
				next_s.eccSingleErrorPriority =
					hwdata[ECC_PRIO_LSB +: 3];
				if (hwdata[ECC_FLAG]) begin
					next_s.eccSingleErrorFlag = 1'b0;
				end
			end
			default: ;
			endcase
		end

		if (s.readPending) begin
			next_s.readPending = 1'b0;
			next_s.hreadyout = 1'b1;
			unique case (s.dataAddr)
			OFS_CONTROL: next_s.hrdata = {16'h0000, s.startBit,
				s.opWriteEnable, s.sequenceErrorFlag, s.stopInIdle, 2'h0,
				s.rowDataCompressed, s.rowUnderrunFlag, 4'h0,
				s.operationSelect};
			OFS_ADDR_HI: next_s.hrdata = {24'h000000, s.targetAddressHigh};
			OFS_ADDR_LO: next_s.hrdata = {16'h0000, s.targetAddressLow};
			OFS_SRC_HI:  next_s.hrdata = {24'h000000, s.srcHigh};
			OFS_SRC_LO:  next_s.hrdata = {16'h0000, s.srcLow, 1'b0};
			OFS_ECC: next_s.hrdata = {25'h0000000,
				s.eccSingleErrorPriority, 2'h0,
				s.eccSingleErrorIrqEnable, s.eccSingleErrorFlag};
			default: next_s.hrdata = 32'h00000000;
			endcase
		end

		if (accept) begin
			next_s.dataAddr = haddr[7:0];
			next_s.dataWrite = hwrite && (hsize == 3'h2);
			if (!hwrite) begin
				next_s.readPending = 1'b1;
				next_s.hreadyout = 1'b0;
			end
		end

		// Flash regulator: sleeps in Idle only when asked to.
		if (s.stopInIdle && cpuIdle && !s.startBit) begin
			next_s.flashAsleep = 1'b1;
		end else if (s.flashAsleep && !cpuIdle) begin
			next_s.flashAsleep = 1'b0;
			next_s.vregTimer = 16'(VREG_WAIT);
		end else if (s.vregTimer != 16'h0000) begin
			next_s.vregTimer = s.vregTimer - 16'h0001;
		end

		unique case (s.fsm)
		FPEC_IDLE: ;
		FPEC_WAITREG: begin
			if (flashUsable) begin
				next_s.timer = 16'h0000;
				next_s.wordIdx = 2'h0;
				next_s.pairIdx = 5'h00;
				if (s.operationSelect == OP_ROW) begin
					next_s.fsm = FPEC_FETCH;
				end else begin
					next_s.pairData = latchData;
					next_s.fsm = FPEC_LOAD;
				end
			end
		end
		FPEC_FETCH: begin
			if (ramAck) begin
				next_s.timer = 16'h0000;
				next_s.wordIdx = s.wordIdx + 2'h1;
				{next_s.srcHigh, next_s.srcLow} =
					23'((source + SRC_STEP) >> 1);
				unique case (s.wordIdx)
				2'h0: next_s.pairData[15:0] = ramData;
				2'h1: begin
					next_s.pairData[23:16] = ramData[7:0];
					if (s.rowDataCompressed) begin
						next_s.pairData[47:40] = ramData[15:8];
					end
				end
				2'h2: next_s.pairData[39:24] = ramData;
				2'h3: next_s.pairData[47:40] = ramData[7:0];
				endcase
				if (s.wordIdx == lastWord) begin
					next_s.fsm = FPEC_LOAD;
				end
			end else if (s.timer == 16'(UNDERRUN - 1)) begin
				next_s.rowUnderrunFlag = 1'b1;
				next_s.sequenceErrorFlag = 1'b1;
				next_s.startBit = 1'b0;
				next_s.fsm = FPEC_IDLE;
			end else begin
				next_s.timer = s.timer + 16'h0001;
			end
		end
		FPEC_LOAD: begin
			next_s.flashOp = s.operationSelect;
			next_s.flashWrWord = {encParity, s.pairData};
			unique case (s.operationSelect)
			OP_PAGE_ERASE: next_s.flashAddr = target & PAGE_MASK;
			OP_BULK_ERASE: next_s.flashAddr = 24'h000000;
			default:       next_s.flashAddr = target & PAIR_MASK;
			endcase
			next_s.fsm = FPEC_PROG;
		end
		FPEC_PROG: begin
			if (flashDone) begin
				if (s.operationSelect == OP_ROW) begin
					{next_s.targetAddressHigh, next_s.targetAddressLow} =
						target + PAIR_STEP;
				end
				if (s.operationSelect == OP_ROW &&
					s.pairIdx != ROW_LAST_PAIR) begin
					next_s.pairIdx = s.pairIdx + 5'h01;
					next_s.wordIdx = 2'h0;
					next_s.timer = 16'h0000;
					next_s.fsm = FPEC_FETCH;
				end else begin
					next_s.startBit = 1'b0;
					next_s.sequenceErrorFlag = 1'b0;
					next_s.fsm = FPEC_IDLE;
				end
			end
		end
		endcase

		// Read path correction; the set of the flag wins over a clear written to OFS_ECC, but sysRst still clears it.
		next_s.rdValid = arrRdValid;
		next_s.eccTrap = arrRdValid && decDouble;
		next_s.resetReq = arrRdValid && decDouble && !trapHandlerPresent;
		if (arrRdValid) begin
			next_s.rdData = decFixed;
			if (decSingle) begin
				next_s.eccSingleErrorFlag = 1'b1;
			end
		end

		// Warm resets leave the power-on-only control bits alone.
		if (sysRst) begin
			next_s.stopInIdle = 1'b0;
			next_s.rowDataCompressed = 1'b0;
			next_s.rowUnderrunFlag = 1'b0;
			next_s.keyStage = KEY_NONE;
			next_s.eccSingleErrorFlag = 1'b0;
			next_s.eccSingleErrorIrqEnable = 1'b0;
			next_s.eccSingleErrorPriority = PRIO_RESET;
		end

		next_s.cpuStall = next_s.startBit;
		// Looking at the next start bit keeps the grant low already in the
		// first busy cycle, when the processor is stalled.
		next_s.powerSaveGrant = powerSaveReq && !next_s.startBit;
		next_s.flashPowerDown = next_s.flashAsleep;
		next_s.flashReq = (next_s.fsm == FPEC_PROG);
		next_s.ramReq = (next_s.fsm == FPEC_FETCH);
		next_s.ramAddr = {next_s.srcHigh, next_s.srcLow, 1'b0};
		next_s.eccIrq = next_s.eccSingleErrorFlag &&
			next_s.eccSingleErrorIrqEnable;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.operationSelect <= CONTROL_RESET[3:0];
			s.fsm <= FPEC_IDLE;
			s.hreadyout <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign hreadyout      = s.hreadyout;
	assign hrdata         = s.hrdata;
	assign hresp          = s.hresp;
	assign cpuStall       = s.cpuStall;
	assign powerSaveGrant = s.powerSaveGrant;
	assign flashPowerDown = s.flashPowerDown;
	assign flashReq       = s.flashReq;
	assign flashOp        = s.flashOp;
	assign flashAddr      = s.flashAddr;
	assign flashWrWord    = s.flashWrWord;
	assign ramReq         = s.ramReq;
	assign ramAddr        = s.ramAddr;
	assign rdValid        = s.rdValid;
	assign rdData         = s.rdData;
	assign eccIrq         = s.eccIrq;
	assign eccPriority    = s.eccSingleErrorPriority;
	assign eccTrap        = s.eccTrap;
	assign resetReq       = s.resetReq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_stall;
		cpuStall == s.startBit && (s.startBit || s.fsm == FPEC_IDLE);
	endproperty
	a_stall: assert property (p_stall) else $error("stall mismatch");

	property p_start_needs_enable;
		$rose(s.startBit) |-> $past(s.keyStage) == KEY_ARMED &&
			s.opWriteEnable;
	endproperty
	a_start_needs_enable: assert property (p_start_needs_enable)
		else $error("start without unlock or enable");

	property p_bad_start;
		s.dataWrite && s.dataAddr == OFS_CONTROL && !s.startBit &&
			hwdata[CTL_START] && s.keyStage != KEY_ARMED
			|=> !s.startBit && s.sequenceErrorFlag;
	endproperty
	a_bad_start: assert property (p_bad_start)
		else $error("improper start not flagged");

	// A normal finish clears the error; only an underrun may leave it set.
	property p_finish;
		$fell(s.startBit) |-> s.fsm == FPEC_IDLE &&
			(($past(s.fsm) == FPEC_PROG) ? !s.sequenceErrorFlag :
			(s.sequenceErrorFlag && s.rowUnderrunFlag));
	endproperty
	a_finish: assert property (p_finish) else $error("bad finish");

	property p_underrun;
		s.fsm == FPEC_FETCH && !ramAck && s.timer == 16'(UNDERRUN - 1)
			|=> s.rowUnderrunFlag && !s.startBit ##1 !ramReq;
	endproperty
	a_underrun: assert property (p_underrun)
		else $error("underrun not handled");

	property p_row_step;
		s.fsm == FPEC_PROG && flashDone && s.operationSelect == OP_ROW
			|=> target == $past(target) + PAIR_STEP;
	endproperty
	a_row_step: assert property (p_row_step)
		else $error("row target not advanced");

	property p_single;
		arrRdValid && decSingle |=> rdValid && s.eccSingleErrorFlag
			&& rdData == $past(decFixed);
	endproperty
	a_single: assert property (p_single) else $error("no correction");

	property p_double;
		arrRdValid && decDouble |=> eccTrap && rdData == $past(arrRdData)
			&& resetReq == !$past(trapHandlerPresent);
	endproperty
	a_double: assert property (p_double) else $error("no trap");

	property p_irq;
		eccIrq |-> s.eccSingleErrorIrqEnable && s.eccSingleErrorFlag;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not gated");

	property p_power_save;
		powerSaveGrant |-> !s.startBit && !cpuStall;
	endproperty
	a_power_save: assert property (p_power_save)
		else $error("power save while busy");
endmodule : fpec_ctrl

// [verif/fpec_flash_model.sv]
`timescale 1ns/1ps
module fpec_flash_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        stall,
	input  wire logic        flashReq,
	input  wire logic        ramReq,
	input  wire logic [23:0] ramAddr,
	output logic             flashDone,
	output logic             ramAck,
	output logic [15:0]      ramData,
	output int               acks
);
	logic [3:0] cnt;
	logic       slow;
	// Prompt and slow completions alternate so both paths get exercised.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{cnt, slow, flashDone, ramAck, ramData} <= '0;
			acks <= 0;
		end else begin
			cnt <= flashReq ? cnt + 4'h1 : 4'h0;
			flashDone <= flashReq && (cnt == (slow ? 4'h9 : 4'h1));
			slow <= slow ^ flashDone;
			ramAck <= ramReq && !ramAck && !stall;
			// Between requests the word is inverted each cycle, so stale data shows every other cycle.
			ramData <= (ramReq && !ramAck) ? ramAddr[15:0] : ~ramData;
			acks <= acks + int'(ramAck);
		end
	end
endmodule : fpec_flash_model

// [verif/tb_flash_program_erase_ecc_controller.sv]
`timescale 1ns/1ps
module tb_flash_program_erase_ecc_controller;
	import fpec_pkg::*;
	typedef struct {string nm; logic [47:0] v;} fpec_exp_t;
	localparam logic [3:0] OPS [5] = '{OP_PAGE_ERASE, OP_DOUBLE_WORD,
		OP_BULK_ERASE, OP_ROW, OP_ROW};
	fpec_exp_t   expQ[$];
	logic        clk, rst, sysRst, hsel, hwrite, hreadyout, hresp, cpuStall;
	logic        powerSaveReq, powerSaveGrant, cpuIdle, flashPowerDown;
	logic        flashReq, flashDone, ramReq, ramAck, arrRdValid, rdValid;
	logic        eccIrq, eccTrap, trapHandlerPresent, resetReq, stall, rdPend;
	wire logic   hready;
	logic [1:0]  htrans;
	logic [2:0]  hsize, eccPriority;
	logic [3:0]  flashOp;
	logic [6:0]  arrRdParity;
	logic [15:0] ramData, c;
	logic [23:0] flashAddr, ramAddr, tgt, src;
	logic [23:0] ea [3];
	logic [31:0] haddr, hwdata, hrdata;
	logic [47:0] latchData, arrRdData, rdData, d;
	logic [54:0] flashWrWord, stored;
	int          errTotal, testsRun, cyc, acks, a0, i, k;

	assign hready = hreadyout;
	always #10 clk = ~clk;

	fpec_ctrl #(.VREG_WAIT(24), .UNDERRUN(8)) DUT (.clk, .rst, .sysRst, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata,
		.hresp, .cpuStall, .powerSaveReq, .powerSaveGrant, .cpuIdle,
		.flashPowerDown, .latchData, .flashReq, .flashOp, .flashAddr,
		.flashWrWord, .flashDone, .ramReq, .ramAddr, .ramAck, .ramData,
		.arrRdValid, .arrRdData, .arrRdParity, .rdValid, .rdData, .eccIrq,
		.eccPriority, .eccTrap, .trapHandlerPresent, .resetReq);
	fpec_flash_model FM (.clk, .rst, .stall, .flashReq, .ramReq, .ramAddr,
		.flashDone, .ramAck, .ramData, .acks);

	task automatic stopTest;
		if (errTotal == 0 && testsRun > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stopTest
	task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
		testsRun++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			errTotal++;
		end
	endtask : chk
	task automatic bus(logic w, logic [7:0] a, logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		do @(posedge clk); while (!hreadyout);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (!hreadyout);
	endtask : bus
	task automatic rd(logic [7:0] a, logic [31:0] e);
		expQ.push_back('{"hrdata", {16'h0, e}});
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic op(logic [15:0] cv);
		bus(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
		bus(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
		bus(1'b1, OFS_CONTROL, {16'h0, cv});
		repeat (2) @(posedge clk);
	endtask : op
	task automatic ecc(logic [47:0] v, logic [6:0] p, logic [47:0] e);
		expQ.push_back('{"rdData", e});
		arrRdValid  <= 1'b1;
		arrRdData   <= v;
		arrRdParity <= p;
		@(posedge clk);
		arrRdValid <= 1'b0;
		arrRdData  <= ~v;
		@(posedge clk);
	endtask : ecc

	// Outputs are read before this edge's updates land, so no race.
	always @(posedge clk) begin
		if ((rdPend && hreadyout) || rdValid) begin
			if (expQ.size() == 0) begin
				chk("unexpected", 48'h1, 48'h0);
			end else begin
				chk(expQ[0].nm, expQ[0].v, rdValid ? rdData : {16'h0, hrdata});
				chk("hresp", 48'h0, 48'(hresp));
				void'(expQ.pop_front());
			end
		end
		if (hreadyout) rdPend <= hsel && htrans[1] && !hwrite;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errTotal++;
			stopTest();
		end
	end

	initial begin
		{clk, sysRst, hsel, hwrite, powerSaveReq, cpuIdle, stall} = '0;
		{arrRdValid, trapHandlerPresent, rdPend, htrans} = '0;
		{haddr, hwdata, arrRdData, arrRdParity, latchData} = '0;
		hsize = 3'h2;
		rst = 1'b1;
		errTotal = 0;
		testsRun = 0;
		cyc = 0;
		void'($urandom(32'h0ccb));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_CONTROL, 32'h0);
		rd(OFS_KEY, 32'h0);
		rd(OFS_ECC, 32'h0);
		rd(8'h1c, 32'h0);
		tgt = 24'($urandom());
		src = 24'($urandom());
		ea = '{tgt & PAGE_MASK, tgt & PAIR_MASK, 24'h0};
		bus(1'b1, OFS_ADDR_HI, {24'h0, tgt[23:16]});
		bus(1'b1, OFS_ADDR_LO, {16'h0, tgt[15:0]});
		bus(1'b1, OFS_SRC_HI, {24'h0, src[23:16]});
		bus(1'b1, OFS_SRC_LO, {16'h0, src[15:0]});
		rd(OFS_ADDR_HI, {24'h0, tgt[23:16]});
		rd(OFS_SRC_LO, {16'h0, src[15:1], 1'b0});
		bus(1'b1, OFS_CONTROL, 32'hc001);
		repeat (2) @(posedge clk);
		chk("cpuStall", 48'h0, 48'(cpuStall));
		rd(OFS_CONTROL, 32'h6001);
		op(16'h8001);
		repeat (2) @(posedge clk);
		chk("cpuStall", 48'h0, 48'(cpuStall));
		rd(OFS_CONTROL, 32'h2001);
		powerSaveReq <= 1'b1;
		for (i = 0; i < 5; i++) begin
			latchData <= 48'({$urandom(), $urandom()});
			a0 = acks;
			c = {2'h3, 4'h0, i == 4, 5'h0, OPS[i]};
			op(c);
			for (k = 0; k < 40 && !flashReq && !ramReq; k++) @(posedge clk);
			chk("cpuStall", 48'h1, 48'(cpuStall));
			chk("powerSaveGrant", 48'h0, 48'(powerSaveGrant));
			if (i < 3) chk("flashOp", 48'(OPS[i]), 48'(flashOp));
			if (i < 3) chk("flashAddr", 48'(ea[i]), 48'(flashAddr));
			if (i > 2) chk("ramAddr", 48'({src[23:1], 1'b0}), 48'(ramAddr));
			if (i == 1) chk("flashWrWord", latchData, flashWrWord[47:0]);
			stored = (i == 1) ? flashWrWord : stored;
			for (k = 0; k < 3000 && cpuStall; k++) @(posedge clk);
			rd(OFS_CONTROL, {16'h0, c & 16'h7fff});
			if (i > 2) chk("ramAcks", (i == 3) ? 48'd128 : 48'd96, 48'(acks - a0));
			// A full uncompressed row moves the source on by 128 words.
			if (i == 3) src = src + 24'h100;
			if (i == 3) rd(OFS_ADDR_LO, {16'h0, 16'(tgt + 24'h80)});
		end
		chk("powerSaveGrant", 48'h1, 48'(powerSaveGrant));
		powerSaveReq <= 1'b0;
		stall <= 1'b1;
		op(16'hc002);
		for (k = 0; k < 200 && (k < 3 || cpuStall); k++) @(posedge clk);
		rd(OFS_CONTROL, 32'h6102);
		stall  <= 1'b0;
		sysRst <= 1'b1;
		repeat (2) @(posedge clk);
		sysRst <= 1'b0;
		rd(OFS_CONTROL, 32'h6002);
		d = stored[47:0];
		ecc(d, stored[54:48], d);
		chk("eccTrap", 48'h0, 48'(eccTrap));
		rd(OFS_ECC, 32'h0);
		k = $urandom_range(47);
		ecc(d ^ (48'h1 << k), stored[54:48], d);
		rd(OFS_ECC, 32'h1);
		chk("eccIrq", 48'h0, 48'(eccIrq));
		bus(1'b1, OFS_ECC, 32'h52);
		repeat (2) @(posedge clk);
		chk("eccIrq", 48'h1, 48'(eccIrq));
		chk("eccPriority", 48'h5, 48'(eccPriority));
		bus(1'b1, OFS_ECC, 32'h53);
		repeat (2) @(posedge clk);
		chk("eccIrq", 48'h0, 48'(eccIrq));
		d = d ^ (48'h3 << (k % 47));
		ecc(d, stored[54:48], d);
		chk("eccTrap", 48'h1, 48'(eccTrap));
		chk("resetReq", 48'h1, 48'(resetReq));
		bus(1'b1, OFS_CONTROL, 32'h5000);
		cpuIdle <= 1'b1;
		repeat (4) @(posedge clk);
		chk("flashPowerDown", 48'h1, 48'(flashPowerDown));
		cpuIdle <= 1'b0;
		op(16'hc001);
		repeat (12) @(posedge clk);
		chk("cpuStall", 48'h1, 48'(cpuStall));
		chk("flashReq", 48'h0, 48'(flashReq));
		for (k = 0; k < 40 && !flashReq; k++) @(posedge clk);
		chk("flashReq", 48'h1, 48'(flashReq));
		for (k = 0; k < 3000 && cpuStall; k++) @(posedge clk);
		chk("flashPowerDown", 48'h0, 48'(flashPowerDown));
		stopTest();
	end
endmodule : tb_flash_program_erase_ecc_controller
